/* include/asf_defs.svh */
// Constants of the asynchronous serial framing block
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH

// Clock rate and oversampling
`define ASF_CLK_HZ      32'h017d7840
`define ASF_OSR         32'h00000010
`define ASF_MID_TICK    4'h7
`define ASF_LAST_TICK   4'hf

// Rate strap codes
`define ASF_SEL_9600    4'h0
`define ASF_SEL_4800    4'h1
`define ASF_SEL_2400    4'h2
`define ASF_SEL_1800    4'h3
`define ASF_SEL_1200    4'h4
`define ASF_SEL_600     4'h5
`define ASF_SEL_300     4'h6
`define ASF_SEL_150     4'h7
`define ASF_SEL_134     4'h8
`define ASF_SEL_110     4'h9

// Bit rates in tenths of a baud
`define ASF_B10_9600    32'h00017700
`define ASF_B10_4800    32'h0000bb80
`define ASF_B10_2400    32'h00005dc0
`define ASF_B10_1800    32'h00004650
`define ASF_B10_1200    32'h00002ee0
`define ASF_B10_600     32'h00001770
`define ASF_B10_300     32'h00000bb8
`define ASF_B10_150     32'h000005dc
`define ASF_B10_134     32'h00000541
`define ASF_B10_110     32'h0000044c

// Reset values
`define ASF_RST_TXD     1'b1
`define ASF_RST_RDY     1'b1
`define ASF_RST_LINE    1'b1

`endif

/* include/asf_pkg.sv */
// Types of the asynchronous serial framing block
package asf_pkg;

    typedef enum logic [4:0] {
        TX_IDLE  = 5'h01,
        TX_START = 5'h02,
        TX_DATA  = 5'h04,
        TX_PAR   = 5'h08,
        TX_STOP  = 5'h10
    } asf_tx_st_t;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'h01,
        RX_START = 5'h02,
        RX_DATA  = 5'h04,
        RX_PAR   = 5'h08,
        RX_STOP  = 5'h10
    } asf_rx_st_t;

    typedef struct packed {
        asf_tx_st_t tx_st;
        logic [3:0] tx_tick;
        logic [2:0] tx_bit;
        logic       tx_nstop;
        logic [7:0] tx_sh;
        logic       tx_par;
        logic [7:0] tx_buf;
        logic       tx_full;
        logic       tx_rdy;
        logic       txd;
        asf_rx_st_t rx_st;
        logic [3:0] rx_tick;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic       rx_perr;
        logic       rx_prev;
        logic       busy;
        logic       done;
        logic       err;
        logic [7:0] rx_data;
    } asf_core_st_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } asf_brg_st_t;

endpackage

/* include/asf_tick_if.sv */
// Rate select and oversample tick between the core and its rate generator
interface asf_tick_if;
    logic [3:0] rate_sel;
    logic       tick;
    modport gen (input rate_sel, output tick);
    modport use_side (output rate_sel, input tick);
endinterface

/* sim/asf_core_tb.sv */
// Self-checking bench of the serial framing core
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); \
        end \
    end

module asf_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Slow core clock figure keeps 110 baud frames short
    localparam int HZ = 160000;
    localparam int B10 [10] = '{96000, 48000, 24000, 18000, 12000, 6000, 3000, 1500, 1345, 1100};
    typedef struct { logic [7:0] d; int lo; int hi; } asf_tb_exp_t;

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic [3:0]  rate_sel = 4'h0;
    logic [1:0]  data_bits = 2'h0;
    logic        par_en = 1'b0;
    logic        par_odd = 1'b0;
    logic        err_en = 1'b1;
    logic        tx_we = 1'b0;
    logic [1:0]  tx_be = 2'h0;
    logic [15:0] tx_wdata = 16'h0000;
    logic        rx_rd = 1'b0;
    logic        rxd, txd, tx_ready, rx_busy, rx_done, busy_q, frm_vld, frm_ok;
    logic [15:0] rx_word, rx_exp;
    logic [7:0]  frm_data;
    logic [31:0] frm_gap;
    logic [15:0] bit_clks = 16'h0010;
    logic [1:0]  nstop = 2'h1;
    logic [31:0] seed = 32'h000044e9;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          dv = 1;
    asf_tb_exp_t tx_exp;
    asf_tb_exp_t tx_q [$];
    logic [15:0] rx_q [$];

    always #20 clk = ~clk;

    asf_core #(.CLK_HZ(HZ)) i_asf_core (
        .CLK(clk), .SRST(srst), .CE(ce), .RATE_SEL(rate_sel), .DATA_BITS(data_bits),
        .PAR_EN(par_en), .PAR_ODD(par_odd), .ERR_EN(err_en), .TX_WE(tx_we),
        .TX_BE(tx_be), .TX_WDATA(tx_wdata), .RX_RD(rx_rd), .RXD(rxd), .TXD(txd),
        .TX_READY(tx_ready), .RX_BUSY(rx_busy), .RX_DONE(rx_done), .RX_WORD(rx_word)
    );

    asf_term_model i_asf_term_model (
        .clk(clk), .txd(txd), .rxd(rxd), .bit_clks(bit_clks),
        .nbits({2'h0, data_bits} + 4'h5), .par_en(par_en), .par_odd(par_odd),
        .nstop(nstop), .frm_vld(frm_vld), .frm_data(frm_data), .frm_ok(frm_ok),
        .frm_gap(frm_gap)
    );

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    function automatic logic [7:0] msk(input logic [7:0] d);
        return d & (8'hff >> (3 - data_bits));
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic set_rate(input int r);
        @(negedge clk);
        rate_sel = r[3:0];
        dv = HZ * 10 / (16 * B10[r]);
        bit_clks = 16'(16 * dv);
        nstop = (r == 9) ? 2'h2 : 2'h1;
        // A long count left from a slower rate must run out before the next frame
        repeat (96) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] d, input logic be0);
        @(negedge clk);
        tx_we = 1'b1;
        tx_wdata = {rnd(), d};
        tx_be = {tx_wdata[8], be0};
        @(negedge clk);
        tx_we = 1'b0;
    endtask

    task automatic wait_ready();
        for (int n = 0; n < 60000 && tx_ready !== 1'b1; n++) @(negedge clk);
    endtask

    task automatic rd();
        logic [7:0] keep;
        @(negedge clk);
        keep = rx_word[7:0];
        rx_rd = 1'b1;
        @(negedge clk);
        rx_rd = 1'b0;
        `CHK(rx_done, 1'b0)
        `CHK(rx_word, {8'h00, keep})
    endtask

    task automatic rx_char(input logic bp, input logic bs, input logic e);
        logic [7:0] r;
        r = msk(rnd());
        rx_q.push_back({e, 7'h00, r});
        i_asf_term_model.send_char(r, bp, bs);
    endtask

    // Two writes back to back and a third while full, with a character coming in
    task automatic duplex();
        logic [7:0] a, b;
        int fb;
        a = msk(rnd());
        b = msk(rnd());
        fb = (1 + data_bits + 5 + par_en + nstop) * bit_clks;
        fork
            rx_char(1'b0, 1'b0, 1'b0);
            begin
                tx_q.push_back(asf_tb_exp_t'{a, 0, 32'h7fffffff});
                wr(a, 1'b1);
                wait_ready();
                tx_q.push_back(asf_tb_exp_t'{b, fb - dv - 4, fb + dv + 4});
                wr(b, 1'b1);
                wr(8'h55, 1'b1);
                wait_ready();
            end
        join
        for (int n = 0; n < 60000 && tx_q.size() > 0; n++) @(negedge clk);
        rd();
    endtask

    always @(posedge frm_vld) begin
        if (tx_q.size() == 0) begin
            miscompares++;
            $display("[ERR] %0t frame not expected", $time);
        end else begin
            tx_exp = tx_q.pop_front();
            `CHK(frm_data, tx_exp.d)
            `CHK(frm_ok, 1'b1)
            `CHK((frm_gap >= tx_exp.lo) && (frm_gap <= tx_exp.hi), 1'b1)
        end
    end

    always @(negedge clk) begin
        busy_q <= rx_busy;
        if (busy_q === 1'b1 && rx_busy === 1'b0 && rx_done === 1'b1) begin
            if (rx_q.size() == 0) begin
                miscompares++;
                $display("[ERR] %0t character not expected", $time);
            end else begin
                rx_exp = rx_q.pop_front();
                `CHK(rx_word, rx_exp)
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            miscompares++;
            $display("[ERR] %0t run too long", $time);
            final_report();
        end
    end

    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        `CHK({txd, tx_ready}, 2'b11)
        `CHK({rx_busy, rx_done, rx_word}, 18'h00000)
        for (int r = 0; r < 10; r++) begin
            set_rate(r);
            duplex();
        end
        $display("test rates done");
        set_rate(0);
        for (int f = 0; f < 12; f++) begin
            @(negedge clk);
            data_bits = f[1:0];
            par_en = (f >= 4);
            par_odd = (f >= 8);
            duplex();
        end
        $display("test formats done");
        par_odd = 1'b0;
        rx_char(1'b1, 1'b0, 1'b1);
        rd();
        rx_char(1'b0, 1'b1, 1'b1);
        rd();
        rx_char(1'b0, 1'b0, 1'b0);
        rx_char(1'b0, 1'b0, 1'b1);
        rd();
        err_en = 1'b0;
        rx_char(1'b1, 1'b1, 1'b0);
        rd();
        err_en = 1'b1;
        $display("test receive errors done");
        fork
            i_asf_term_model.false_start();
            begin
                repeat (4) @(negedge clk);
                `CHK(rx_busy, 1'b1)
            end
        join
        `CHK({rx_busy, rx_done}, 2'b00)
        // Write without the low byte enable must leave the transmitter idle
        fork
            rx_char(1'b0, 1'b0, 1'b0);
            begin
                wr(8'h3c, 1'b0);
                `CHK(tx_ready, 1'b1)
                repeat (80) @(negedge clk);
                `CHK({rx_busy, txd}, 2'b11)
            end
        join
        rd();
        // Clock enable low freezes the core, so this write must not land
        ce = 1'b0;
        wr(8'h5a, 1'b1);
        `CHK({tx_ready, txd}, 2'b11)
        ce = 1'b1;
        $display("test refusals done");
        `CHK(tx_q.size() + rx_q.size(), 0)
        final_report();
    end
endmodule // asf_core_tb

/* sim/asf_term_model.sv */
// Serial terminal model facing the core's line pins
module asf_term_model (
    // Clock and line
    input  wire logic        clk,
    input  wire logic        txd,
    output logic             rxd,
    // Frame format
    input  wire logic [15:0] bit_clks,
    input  wire logic [3:0]  nbits,
    input  wire logic        par_en,
    input  wire logic        par_odd,
    input  wire logic [1:0]  nstop,
    // Decoded frame
    output logic             frm_vld,
    output logic [7:0]       frm_data,
    output logic             frm_ok,
    output logic [31:0]      frm_gap
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] cyc = '0;
    logic [31:0] t0  = '0;

    initial begin
        rxd = 1'b1;
        frm_vld = 1'b0;
    end

    always @(posedge clk) cyc <= cyc + 32'h1;

    // Mid-bit sampling from the start edge; a short stop shows up as a late or missed start
    always begin
        @(negedge txd);
        frm_gap = cyc - t0;
        t0 = cyc;
        frm_ok = 1'b1;
        frm_data = 8'h00;
        repeat (bit_clks / 2) @(posedge clk);
        frm_ok &= ~txd;
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_clks) @(posedge clk);
            frm_data[i] = txd;
        end
        if (par_en) begin
            repeat (bit_clks) @(posedge clk);
            frm_ok &= (txd == (^frm_data ^ par_odd));
        end
        for (int i = 0; i < nstop; i++) begin
            repeat (bit_clks) @(posedge clk);
            frm_ok &= txd;
        end
        frm_vld = 1'b1;
        @(posedge clk);
        frm_vld = 1'b0;
    end

    // Data must already be cut to the character length
    task automatic send_char(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        @(negedge clk);
        rxd = 1'b0;
        repeat (bit_clks) @(negedge clk);
        for (int i = 0; i < nbits; i++) begin
            rxd = d[i];
            repeat (bit_clks) @(negedge clk);
        end
        if (par_en) begin
            rxd = ^d ^ par_odd ^ bad_par;
            repeat (bit_clks) @(negedge clk);
        end
        rxd = ~bad_stop;
        repeat (bit_clks) @(negedge clk);
        rxd = 1'b1;
        repeat (bit_clks * nstop) @(negedge clk);
    endtask

    task automatic false_start();
        @(negedge clk);
        rxd = 1'b0;
        repeat (bit_clks / 4) @(negedge clk);
        rxd = 1'b1;
        repeat (bit_clks * 2) @(negedge clk);
    endtask
endmodule // asf_term_model

/* src/asf_brg.sv */
// Oversampling rate generator shared by transmitter and receiver
`include "asf_defs.svh"
module asf_brg
    import asf_pkg::*;
#(
    parameter int CLK_HZ = `ASF_CLK_HZ
) (
    // Clock and control
    input  wire logic CLK,
    input  wire logic SRST,
    input  wire logic CE,
    // Tick output
    asf_tick_if.gen   t
);

    asf_brg_st_t q;
    asf_brg_st_t d;

    function automatic logic [15:0] asf_div(input logic [3:0] s);
        logic [31:0] b;
        case (s)
            `ASF_SEL_9600: b = `ASF_B10_9600;
            `ASF_SEL_4800: b = `ASF_B10_4800;
            `ASF_SEL_2400: b = `ASF_B10_2400;
            `ASF_SEL_1800: b = `ASF_B10_1800;
            `ASF_SEL_1200: b = `ASF_B10_1200;
            `ASF_SEL_600:  b = `ASF_B10_600;
            `ASF_SEL_300:  b = `ASF_B10_300;
            `ASF_SEL_150:  b = `ASF_B10_150;
            `ASF_SEL_134:  b = `ASF_B10_134;
            `ASF_SEL_110:  b = `ASF_B10_110;
            default:       b = `ASF_B10_9600;
        endcase
        // Truncating division: the rate error stays below one clock per tick
        asf_div = 16'((32'(CLK_HZ) * 32'h0000000a) / (`ASF_OSR * b));
    endfunction

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == 16'h0000) begin
            d.cnt  = asf_div(t.rate_sel) - 16'h0001;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt - 16'h0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            q <= '0;
        end else if (CE) begin
            q <= d;
        end
    end

    assign t.tick = q.tick;

    // The reload seen with a tick was taken from the select of the cycle before
    a_tick_period: assert property (@(posedge CLK) disable iff (SRST)
        q.tick |-> q.cnt == asf_div($past(t.rate_sel)) - 16'h0001)
        else $error("tick reload does not match the selected rate");

endmodule // asf_brg

/* src/asf_core.sv */
// Asynchronous start/stop serial transmitter and receiver
// Functional notes
// - Every character on either line opens with one start bit at space (zero).
// - Every character closes with a stop element at mark (one).
// - The bit rate is one of ten strap settings from 9600 down to 110 baud.
// - Transmitter and receiver always share the one selected rate.
// - 110 baud sends two stop bits, every other rate sends one.
// - A character carries five to eight data bits by strap.
// - With parity on, one parity bit follows the last data bit before the stop.
// - Parity and the error flag are set by static straps, not by software.
// - Transmit and receive paths run independently, full or half duplex.
// - Host moves data by programmed word or byte accesses.
// - A mark to space edge starts reception; busy holds until the first stop bit.
// - A first stop bit sampled at space raises the error flag.
// - A parity mismatch with parity on raises the same error flag.
// - A character completing before the previous one is collected raises the error flag.
`include "asf_defs.svh"
module asf_core
    import asf_pkg::*;
#(
    parameter int CLK_HZ = `ASF_CLK_HZ
) (
    // Clock and control
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic        CE,
    // Configuration straps
    input  wire logic [3:0]  RATE_SEL,
    input  wire logic [1:0]  DATA_BITS,
    input  wire logic        PAR_EN,
    input  wire logic        PAR_ODD,
    input  wire logic        ERR_EN,
    // Host transmit write
    input  wire logic        TX_WE,
    input  wire logic [1:0]  TX_BE,
    input  wire logic [15:0] TX_WDATA,
    // Host receive read
    input  wire logic        RX_RD,
    // Serial line
    input  wire logic        RXD,
    output logic             TXD,
    // Status and received word
    output logic             TX_READY,
    output logic             RX_BUSY,
    output logic             RX_DONE,
    output logic [15:0]      RX_WORD
);

    asf_core_st_t q;
    asf_core_st_t d;
    logic [2:0]   last_bit;
    logic         two_stop;
    logic         rx_fin;
    logic         stop_smp;

    asf_tick_if tk ();

    asf_brg #(.CLK_HZ(CLK_HZ)) u_brg (
        .CLK  (CLK),
        .SRST (SRST),
        .CE   (CE),
        .t    (tk)
    );

    // One generator feeds both directions
    assign tk.rate_sel = RATE_SEL;

    function automatic logic asf_par(input logic [7:0] v, input logic [2:0] lb,
                                     input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 8; i++) begin
            if (3'(i) <= lb) begin
                p = p ^ v[i];
            end
        end
        asf_par = p;
    endfunction

    function automatic logic [7:0] asf_mask(input logic [7:0] v, input logic [2:0] lb);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (3'(i) <= lb) begin
                m[i] = v[i];
            end
        end
        asf_mask = m;
    endfunction

    assign last_bit = {1'b0, DATA_BITS} + 3'h4;
    assign two_stop = (RATE_SEL == `ASF_SEL_110);

    always_comb begin
        d        = q;
        rx_fin   = 1'b0;
        stop_smp = 1'b0;

        // Transmitter; a start may begin mid tick, so its first bit runs short
        // by under one sixteenth of a bit
        case (q.tx_st)
            TX_IDLE: begin
                d.txd = 1'b1;
                if (q.tx_full) begin
                    d.tx_sh   = q.tx_buf;
                    d.tx_par  = asf_par(q.tx_buf, last_bit, PAR_ODD);
                    d.tx_full = 1'b0;
                    d.tx_rdy  = 1'b1;
                    d.tx_tick = 4'h0;
                    d.tx_st   = TX_START;
                    d.txd     = 1'b0;
                end
            end
            TX_START: begin
                if (tk.tick) begin
                    d.tx_tick = q.tx_tick + 4'h1;
                    if (q.tx_tick == `ASF_LAST_TICK) begin
                        d.tx_bit = 3'h0;
                        d.tx_st  = TX_DATA;
                        d.txd    = q.tx_sh[0];
                    end
                end
            end
            TX_DATA: begin
                if (tk.tick) begin
                    d.tx_tick = q.tx_tick + 4'h1;
                    if (q.tx_tick == `ASF_LAST_TICK) begin
                        if (q.tx_bit == last_bit) begin
                            if (PAR_EN) begin
                                d.tx_st = TX_PAR;
                                d.txd   = q.tx_par;
                            end else begin
                                d.tx_st    = TX_STOP;
                                d.txd      = 1'b1;
                                d.tx_nstop = two_stop;
                            end
                        end else begin
                            d.tx_bit = q.tx_bit + 3'h1;
                            d.txd    = q.tx_sh[q.tx_bit + 3'h1];
                        end
                    end
                end
            end
            TX_PAR: begin
                if (tk.tick) begin
                    d.tx_tick = q.tx_tick + 4'h1;
                    if (q.tx_tick == `ASF_LAST_TICK) begin
                        d.tx_st    = TX_STOP;
                        d.txd      = 1'b1;
                        d.tx_nstop = two_stop;
                    end
                end
            end
            TX_STOP: begin
                d.txd = 1'b1;
                if (tk.tick) begin
                    d.tx_tick = q.tx_tick + 4'h1;
                    if (q.tx_tick == `ASF_LAST_TICK) begin
                        if (q.tx_nstop) begin
                            d.tx_nstop = 1'b0;
                        end else begin
                            d.tx_st = TX_IDLE;
                        end
                    end
                end
            end
            default: begin
                d.tx_st = TX_IDLE;
                d.txd   = 1'b1;
            end
        endcase

        // Host load of the transmit buffer; a high-byte-only write carries no
        // character and a write while full is dropped
        if (TX_WE && TX_BE[0] && !q.tx_full) begin
            d.tx_buf  = TX_WDATA[7:0];
            d.tx_full = 1'b1;
            d.tx_rdy  = 1'b0;
        end

        // Host collection clears first so a completing character wins
        if (RX_RD) begin
            d.done = 1'b0;
            d.err  = 1'b0;
        end

        // Receiver, separate from the transmitter apart from the shared tick
        d.rx_prev = RXD;
        case (q.rx_st)
            RX_IDLE: begin
                if (q.rx_prev && !RXD) begin
                    d.rx_st   = RX_START;
                    d.busy    = 1'b1;
                    d.rx_tick = 4'h0;
                    d.rx_sh   = 8'h00;
                    d.rx_data = 8'h00;
                    d.rx_perr = 1'b0;
                end
            end
            RX_START: begin
                if (tk.tick) begin
                    d.rx_tick = q.rx_tick + 4'h1;
                    if (q.rx_tick == `ASF_MID_TICK) begin
                        d.rx_tick = 4'h0;
                        d.rx_bit  = 3'h0;
                        if (RXD) begin
                            d.rx_st = RX_IDLE;
                            d.busy  = 1'b0;
                        end else begin
                            d.rx_st = RX_DATA;
                        end
                    end
                end
            end
            RX_DATA: begin
                if (tk.tick) begin
                    d.rx_tick = q.rx_tick + 4'h1;
                    if (q.rx_tick == `ASF_LAST_TICK) begin
                        d.rx_sh[q.rx_bit] = RXD;
                        if (q.rx_bit == last_bit) begin
                            d.rx_st = PAR_EN ? RX_PAR : RX_STOP;
                        end else begin
                            d.rx_bit = q.rx_bit + 3'h1;
                        end
                    end
                end
            end
            RX_PAR: begin
                if (tk.tick) begin
                    d.rx_tick = q.rx_tick + 4'h1;
                    if (q.rx_tick == `ASF_LAST_TICK) begin
                        d.rx_perr = RXD != asf_par(q.rx_sh, last_bit, PAR_ODD);
                        d.rx_st   = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (tk.tick) begin
                    d.rx_tick = q.rx_tick + 4'h1;
                    if (q.rx_tick == `ASF_LAST_TICK) begin
                        stop_smp  = 1'b1;
                        rx_fin    = 1'b1;
                        d.busy    = 1'b0;
                        d.rx_st   = RX_IDLE;
                        d.rx_data = asf_mask(q.rx_sh, last_bit);
                        d.done    = 1'b1;
                        // Flag gated by strap: frame, parity, overrun
                        if (ERR_EN && (!RXD || q.rx_perr || q.done)) begin
                            d.err = 1'b1;
                        end
                    end
                end
            end
            default: begin
                d.rx_st = RX_IDLE;
                d.busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            q         <= '0;
            q.tx_st   <= TX_IDLE;
            q.rx_st   <= RX_IDLE;
            q.txd     <= `ASF_RST_TXD;
            q.tx_rdy  <= `ASF_RST_RDY;
            q.rx_prev <= `ASF_RST_LINE;
        end else if (CE) begin
            q <= d;
        end
    end

    assign TXD      = q.txd;
    assign TX_READY = q.tx_rdy;
    assign RX_BUSY  = q.busy;
    assign RX_DONE  = q.done;
    assign RX_WORD  = {q.err, 7'h00, q.rx_data};

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    a_tx_start_low: assert property (q.tx_st == TX_START |-> !q.txd)
        else $error("start bit not at space");
    a_tx_stop_high: assert property (q.tx_st == TX_STOP |-> q.txd)
        else $error("stop element not at mark");
    a_tx_stop_count: assert property ($rose(q.tx_st == TX_STOP) |-> q.tx_nstop == two_stop)
        else $error("stop bit count does not follow the rate");
    a_tx_par_slot: assert property (q.tx_st == TX_PAR |-> q.txd == q.tx_par && PAR_EN)
        else $error("parity slot wrong");
    a_tx_load_busy: assert property (CE && TX_WE && TX_BE[0] && q.tx_rdy |=> !TX_READY)
        else $error("buffer load did not clear ready");
    a_rx_start_busy: assert property (CE && q.rx_st == RX_IDLE && q.rx_prev && !RXD
        |=> RX_BUSY ##0 q.rx_st == RX_START)
        else $error("start edge not taken");
    a_rx_mid_reject: assert property (CE && tk.tick && q.rx_st == RX_START
        && q.rx_tick == `ASF_MID_TICK && RXD |=> q.rx_st == RX_IDLE && !RX_BUSY)
        else $error("false start not rejected");
    a_rx_frame_err: assert property (CE && stop_smp && !RXD && ERR_EN |=> RX_WORD[15])
        else $error("framing error not flagged");
    a_rx_par_err: assert property (CE && stop_smp && q.rx_perr && ERR_EN |=> RX_WORD[15])
        else $error("parity error not flagged");
    a_rx_overrun: assert property (CE && rx_fin && q.done && ERR_EN |=> RX_WORD[15])
        else $error("overrun not flagged");
    a_rx_set_wins: assert property (CE && rx_fin |=> RX_DONE && !RX_BUSY)
        else $error("completed character lost");
    a_err_strap: assert property (!ERR_EN && !q.err |=> !q.err)
        else $error("error flag set while disabled");

    c_tx_char: cover property ($fell(q.tx_st == TX_STOP));
    c_rx_char: cover property (rx_fin && !RX_WORD[15]);
    c_rx_err: cover property (rx_fin && ERR_EN && !RXD);
    c_duplex: cover property (q.tx_st == TX_DATA && q.rx_st == RX_DATA);

endmodule // asf_core
